// ===== rtl/link_pkg.sv
// Shared constants and types for the one-pin voltage configuration link.
package link_pkg;
  // Timing, derived from the 8 ns clock period.
  localparam int CLK_PERIOD_NS = 8;
  localparam int TIMEOUT_NS = 520000;
  localparam int TIMEOUT_CYCLES = TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int STARTUP_NS = 170000;
  localparam int STARTUP_CYCLES = STARTUP_NS / CLK_PERIOD_NS;
  localparam int ACK_HOLD_NS = 520000;
  localparam int ACK_HOLD_CYCLES = ACK_HOLD_NS / CLK_PERIOD_NS;
  localparam int ACK_VALID_NS = 2000;
  localparam int ACK_VALID_CYCLES = (ACK_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Counter layout.
  localparam int CNT_W = 17;
  localparam logic [16:0] CNT_MAX = 17'h1_FFFF;
  localparam logic [16:0] CNT_ZERO = 17'h0_0000;
  // Frame layout.
  localparam int FRAME_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] FRAME_LAST = 5'h0F;
  localparam logic [4:0] BITS_ZERO = 5'h00;
  localparam int ACK_BIT = 7;
  localparam int SEL_MSB = 6;
  localparam int SEL_LSB = 5;
  localparam int CODE_MSB = 4;
  localparam int CODE_W = 5;
  // Register select field encodings.
  localparam logic [1:0] SEL_CONV1_LOW = 2'h0;
  localparam logic [1:0] SEL_CONV1_HIGH = 2'h1;
  localparam logic [1:0] SEL_CONV2 = 2'h2;
  // Voltage register reset contents.
  localparam logic [4:0] CODE_RESET = 5'h00;
  // Frame buffer shape.
  localparam int FIFO_DEPTH = 16;
  // Positions in the input synchroniser vector.
  localparam int SYNC_W = 4;
  localparam int SYNC_MODE = 0;
  localparam int SYNC_VSEL = 1;
  localparam int SYNC_EN1 = 2;
  localparam int SYNC_EN2 = 3;
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_START = 3'h1,
    ST_IDLE = 3'h2,
    ST_ACK_WAIT = 3'h3,
    ST_ACK_DRIVE = 3'h4
  } link_state_t;
endpackage

// ===== rtl/voltage_link.sv
// One-pin mode and voltage configuration receiver with its frame buffer.
`timescale 1ns/1ps

module frame_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t st_reg;
  fifo_state_t st_next;
  logic push;
  logic pop;

  assign in_ready = st_reg.count != FULL;
  assign out_valid = st_reg.count != '0;
  assign out_data = st_reg.mem[st_reg.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers wrap naturally because the depth is a power of two.
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr_ptr] = in_data;
      st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
    end
    case ({push, pop})
      2'b10: begin
        st_next.count = st_reg.count + 1'b1;
      end
      2'b01: begin
        st_next.count = st_reg.count - 1'b1;
      end
      default: begin
        st_next.count = st_reg.count;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

module voltage_link #(
  // Arbitrary own address; set it to the address of the real part.
  parameter logic [7:0] DEVICE_ADDRESS = 8'h5A,
  parameter int TIMEOUT_CYCLES = link_pkg::TIMEOUT_CYCLES,
  parameter int STARTUP_CYCLES = link_pkg::STARTUP_CYCLES,
  parameter int ACK_HOLD_CYCLES = link_pkg::ACK_HOLD_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Shared mode and data pin, open drain
  input wire logic mode_data_in,
  output logic mode_data_out,
  output logic mode_data_oe,
  // Control pins
  input wire logic voltage_select_pin,
  input wire logic converter1_enable,
  input wire logic converter2_enable,
  // Converter side
  input wire logic vout_update_ready,
  output logic forced_pwm,
  output logic [4:0] conv1_voltage_code,
  output logic [4:0] conv2_voltage_code,
  output logic interface_ready
);
  localparam logic [16:0] TIMEOUT_LAST = 17'(TIMEOUT_CYCLES - 1);
  localparam logic [16:0] STARTUP_LAST = 17'(STARTUP_CYCLES - 1);
  localparam logic [16:0] ACK_HOLD_LAST = 17'(ACK_HOLD_CYCLES - 1);
  localparam logic [16:0] ACK_VALID_LAST = 17'(link_pkg::ACK_VALID_CYCLES - 1);

  typedef struct packed {
    logic [link_pkg::SYNC_W-1:0] sync1;
    logic [link_pkg::SYNC_W-1:0] sync2;
    logic line_prev;
    link_pkg::link_state_t state;
    logic [link_pkg::CNT_W-1:0] timer;
    logic [link_pkg::CNT_W-1:0] low_cnt;
    logic [link_pkg::CNT_W-1:0] high_cnt;
    logic cell_open;
    logic [4:0] bit_cnt;
    logic [link_pkg::FRAME_W-1:0] shift;
    logic bad;
    logic power_save;
    logic [4:0] conv1_high;
    logic [4:0] conv1_low;
    logic [4:0] conv2;
    logic [4:0] conv1_out;
  } link_state_reg_t;

  link_state_reg_t st_reg;
  link_state_reg_t st_next;
  logic line;
  logic fall;
  logic rx_on;
  logic acking;
  logic bit_one;
  logic bit_zero;
  logic [link_pkg::FRAME_W-1:0] word_next;
  logic last_cell;
  logic frame_good;
  logic frame_accepted;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [link_pkg::BYTE_W-1:0] fifo_out_data;
  logic fire;

  function automatic logic [1:0] sel_field(input logic [7:0] data);
    sel_field = data[link_pkg::SEL_MSB:link_pkg::SEL_LSB];
  endfunction

  function automatic logic [4:0] code_field(input logic [7:0] data);
    code_field = data[link_pkg::CODE_MSB:0];
  endfunction

  assign line = st_reg.sync2[link_pkg::SYNC_MODE];
  assign fall = !line && st_reg.line_prev;
  assign rx_on = st_reg.sync2[link_pkg::SYNC_EN1] || st_reg.sync2[link_pkg::SYNC_EN2];
  assign acking = st_reg.state == link_pkg::ST_ACK_WAIT || st_reg.state == link_pkg::ST_ACK_DRIVE;

  // Widened by one bit so that doubling a saturated count cannot wrap.
  assign bit_one = {1'b0, st_reg.high_cnt} >= {st_reg.low_cnt, 1'b0};
  assign bit_zero = {1'b0, st_reg.low_cnt} >= {st_reg.high_cnt, 1'b0};
  assign word_next = {st_reg.shift[link_pkg::FRAME_W-2:0], bit_one};

  // A frame whose first edge came from the mode drop ends one bit out of step, fails the address and is lost.
  assign last_cell = st_reg.state == link_pkg::ST_IDLE && fall && st_reg.cell_open &&
                     st_reg.bit_cnt == link_pkg::FRAME_LAST;
  assign frame_good = last_cell && !st_reg.bad && (bit_one || bit_zero) &&
                      word_next[link_pkg::FRAME_W-1:link_pkg::BYTE_W] == DEVICE_ADDRESS;
  assign frame_accepted = frame_good && fifo_in_ready;
  assign fire = fifo_out_valid && vout_update_ready;

  frame_fifo #(
    .WIDTH(link_pkg::BYTE_W),
    .DEPTH(link_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(frame_good),
    .in_ready(fifo_in_ready),
    .in_data(word_next[link_pkg::BYTE_W-1:0]),
    .out_valid(fifo_out_valid),
    .out_ready(vout_update_ready),
    .out_data(fifo_out_data)
  );

  always_comb begin
    st_next = st_reg;
    st_next.sync1 = {converter2_enable, converter1_enable, voltage_select_pin, mode_data_in};
    st_next.sync2 = st_reg.sync1;
    st_next.line_prev = line;

    // Mode tracking runs whether or not the receiver is enabled.
    if (line) begin
      st_next.power_save = 1'b0;
      if (st_reg.high_cnt != link_pkg::CNT_MAX) begin
        st_next.high_cnt = st_reg.high_cnt + 1'b1;
      end
    end else begin
      if (st_reg.low_cnt != link_pkg::CNT_MAX) begin
        st_next.low_cnt = st_reg.low_cnt + 1'b1;
      end
      // Our own acknowledge pulse holds the line low, so it must not count as a mode request.
      if (!fall && !acking && st_reg.low_cnt == TIMEOUT_LAST) begin
        st_next.power_save = 1'b1;
        st_next.cell_open = 1'b0;
        st_next.bit_cnt = link_pkg::BITS_ZERO;
      end
    end
    if (fall) begin
      st_next.low_cnt = link_pkg::CNT_ZERO;
      st_next.high_cnt = link_pkg::CNT_ZERO;
    end

    case (st_reg.state)
      link_pkg::ST_OFF: begin
        st_next.timer = link_pkg::CNT_ZERO;
        st_next.cell_open = 1'b0;
        st_next.bit_cnt = link_pkg::BITS_ZERO;
        if (rx_on) begin
          st_next.state = link_pkg::ST_START;
        end
      end
      link_pkg::ST_START: begin
        if (st_reg.timer == STARTUP_LAST) begin
          st_next.timer = link_pkg::CNT_ZERO;
          st_next.state = link_pkg::ST_IDLE;
        end else begin
          st_next.timer = st_reg.timer + 1'b1;
        end
      end
      link_pkg::ST_IDLE: begin
        if (fall && st_reg.cell_open) begin
          st_next.bad = st_reg.bad || !(bit_one || bit_zero);
          st_next.shift = word_next;
          st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
          // The gap of end-of-stream and start interval between the bytes is not a bit.
          if (st_reg.bit_cnt == link_pkg::BYTE_BITS - 1'b1) begin
            st_next.cell_open = 1'b0;
          end
          if (last_cell) begin
            st_next.cell_open = 1'b0;
            st_next.bit_cnt = link_pkg::BITS_ZERO;
            if (frame_accepted && word_next[link_pkg::ACK_BIT]) begin
              st_next.timer = link_pkg::CNT_ZERO;
              st_next.state = link_pkg::ST_ACK_WAIT;
            end
          end
        end else if (fall) begin
          st_next.cell_open = 1'b1;
          if (st_reg.bit_cnt == link_pkg::BITS_ZERO) begin
            st_next.bad = 1'b0;
          end
        end
      end
      link_pkg::ST_ACK_WAIT: begin
        if (st_reg.timer == ACK_VALID_LAST) begin
          st_next.timer = link_pkg::CNT_ZERO;
          st_next.state = link_pkg::ST_ACK_DRIVE;
        end else begin
          st_next.timer = st_reg.timer + 1'b1;
        end
      end
      link_pkg::ST_ACK_DRIVE: begin
        if (st_reg.timer == ACK_HOLD_LAST) begin
          st_next.timer = link_pkg::CNT_ZERO;
          st_next.low_cnt = link_pkg::CNT_ZERO;
          st_next.high_cnt = link_pkg::CNT_ZERO;
          st_next.state = link_pkg::ST_IDLE;
        end else begin
          st_next.timer = st_reg.timer + 1'b1;
        end
      end
      default: begin
        st_next.state = link_pkg::ST_OFF;
      end
    endcase

    if (!rx_on) begin
      st_next.state = link_pkg::ST_OFF;
    end

    // Only buffered frames reach the registers, and the enables never clear them.
    if (fire) begin
      case (sel_field(fifo_out_data))
        link_pkg::SEL_CONV1_LOW: begin
          st_next.conv1_low = code_field(fifo_out_data);
        end
        link_pkg::SEL_CONV1_HIGH: begin
          st_next.conv1_high = code_field(fifo_out_data);
        end
        link_pkg::SEL_CONV2: begin
          st_next.conv2 = code_field(fifo_out_data);
        end
        default: begin
          st_next.conv2 = st_reg.conv2;
        end
      endcase
    end
    st_next.conv1_out = st_reg.sync2[link_pkg::SYNC_VSEL] ? st_reg.conv1_high : st_reg.conv1_low;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '{
        sync1: '0, sync2: '0, line_prev: 1'b0, state: link_pkg::ST_OFF,
        timer: link_pkg::CNT_ZERO, low_cnt: link_pkg::CNT_ZERO, high_cnt: link_pkg::CNT_ZERO,
        cell_open: 1'b0, bit_cnt: link_pkg::BITS_ZERO, shift: '0, bad: 1'b0, power_save: 1'b0,
        conv1_high: link_pkg::CODE_RESET, conv1_low: link_pkg::CODE_RESET,
        conv2: link_pkg::CODE_RESET, conv1_out: link_pkg::CODE_RESET
      };
    end else begin
      st_reg <= st_next;
    end
  end

  assign mode_data_out = 1'b0;
  assign mode_data_oe = st_reg.state == link_pkg::ST_ACK_DRIVE;
  assign forced_pwm = !st_reg.power_save;
  assign conv1_voltage_code = st_reg.conv1_out;
  assign conv2_voltage_code = st_reg.conv2;
  assign interface_ready = st_reg.state == link_pkg::ST_IDLE || acking;

  property p_fast_pwm;
    @(posedge clk) disable iff (reset) line |=> !st_reg.power_save;
  endproperty
  a_fast_pwm: assert property (p_fast_pwm) else $error("Forced PWM not restored after high line.");
  property p_timeout;
    @(posedge clk) disable iff (reset)
      (!line && !fall && !acking && st_reg.low_cnt == TIMEOUT_LAST) |=> st_reg.power_save;
  endproperty
  a_timeout: assert property (p_timeout) else $error("Power save not entered at timeout.");
  property p_psave_low;
    @(posedge clk) disable iff (reset) st_reg.power_save |-> !st_reg.line_prev;
  endproperty
  a_psave_low: assert property (p_psave_low) else $error("Power save while line was high.");
  property p_rx_pwm;
    @(posedge clk) disable iff (reset)
      (st_reg.cell_open || st_reg.bit_cnt != link_pkg::BITS_ZERO) |-> forced_pwm;
  endproperty
  a_rx_pwm: assert property (p_rx_pwm) else $error("Power save during frame reception.");
  property p_vsel;
    @(posedge clk) disable iff (reset)
      rx_on |=> conv1_voltage_code ==
        $past(st_reg.sync2[link_pkg::SYNC_VSEL] ? st_reg.conv1_high : st_reg.conv1_low);
  endproperty
  a_vsel: assert property (p_vsel) else $error("Converter 1 code does not follow select pin.");
  property p_rx_off;
    @(posedge clk) disable iff (reset) !rx_on |=> st_reg.state == link_pkg::ST_OFF && !mode_data_oe;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("Receiver active with both enables low.");
  property p_startup;
    @(posedge clk) disable iff (reset)
      st_reg.state == link_pkg::ST_START |-> !interface_ready && st_reg.timer <= STARTUP_LAST;
  endproperty
  a_startup: assert property (p_startup) else $error("Startup interval overrun or ready early.");
  property p_ack_cause;
    @(posedge clk) disable iff (reset)
      $rose(st_reg.state == link_pkg::ST_ACK_WAIT) |-> $past(frame_accepted && word_next[link_pkg::ACK_BIT]);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("Acknowledge without valid request.");
  property p_ack_hold;
    @(posedge clk) disable iff (reset) mode_data_oe |-> st_reg.timer <= ACK_HOLD_LAST;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("Acknowledge pull-down held too long.");
  property p_ack_delay;
    @(posedge clk) disable iff (reset)
      $rose(mode_data_oe) |-> $past(st_reg.state == link_pkg::ST_ACK_WAIT) && $past(st_reg.timer) == ACK_VALID_LAST;
  endproperty
  a_ack_delay: assert property (p_ack_delay) else $error("Pull-down started before valid delay.");
  property p_write;
    @(posedge clk) disable iff (reset)
      $changed(st_reg.conv2) |-> $past(fire && sel_field(fifo_out_data) == link_pkg::SEL_CONV2);
  endproperty
  a_write: assert property (p_write) else $error("Converter 2 code changed without a frame.");
endmodule

// ===== verif/link_host.sv
// Host model that drives the shared open-drain mode and data line with coded frames.
`timescale 1ns/1ps
module link_host (
  // Clock
  input wire logic clk,
  // Shared line
  input wire logic mode_data_oe,
  output logic line,
  output logic busy
);
  logic host_low;
  int run;
  int ack_len;
  // The pull-up gives a high level only while nobody pulls the line low.
  assign line = ~(host_low | mode_data_oe);
  initial begin
    host_low = 1'b0;
    busy = 1'b0;
    run = 0;
    ack_len = 0;
  end
  always @(posedge clk) begin
    if (mode_data_oe === 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      ack_len <= run;
      run <= 0;
    end
  end
  task automatic hold(input logic low, input int n);
    @(negedge clk);
    host_low = low;
    repeat (n - 1) @(negedge clk);
  endtask
  task automatic send_byte(input logic [7:0] b, input int s, input int bad_pos);
    for (int i = 7; i >= 0; i--) begin
      if (i == bad_pos) begin
        hold(1'b1, 2 * s);
        hold(1'b0, 2 * s);
      end else begin
        hold(1'b1, b[i] ? s : 3 * s);
        hold(1'b0, b[i] ? 3 * s : s);
      end
    end
  endtask
  task automatic frame(input logic [7:0] addr, input logic [7:0] data, input int s, input int bad_pos,
                       output logic acked, output int dly);
    int n;
    hold(1'b0, 40);
    busy = 1'b1;
    send_byte(addr, s, -1);
    hold(1'b1, 40);
    hold(1'b0, 40);
    send_byte(data, s, bad_pos);
    @(negedge clk);
    host_low = 1'b1;
    busy = 1'b0;
    n = 0;
    while (mode_data_oe !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    dly = n;
    @(negedge clk);
    host_low = 1'b0;
    @(posedge clk);
    acked = ~line;
    n = 0;
    while (mode_data_oe === 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    // The pulse length is only registered on the edge after the pull-down ends.
    @(negedge clk);
  endtask
endmodule

// ===== verif/test_voltage_link.sv
// Self-checking testbench for the one-pin voltage configuration receiver.
`timescale 1ns/1ps
module test_voltage_link;
  localparam int TMO = 400;
  localparam int STUP = 50;
  localparam int AHOLD = 100;
  // Own address value is arbitrary.
  localparam logic [7:0] OWN_ADDR = 8'h5a;
  logic clk, reset, vsel, en1, en2, upd_ready;
  logic line, busy, oe, pwm, ready, dout;
  logic [4:0] c1, c2;
  logic [4:0] regs [3];
  logic [4:0] pend [$];
  logic [31:0] seed;
  int error_cnt, num_checks, pwm_drop;

  voltage_link #(.DEVICE_ADDRESS(OWN_ADDR), .TIMEOUT_CYCLES(TMO), .STARTUP_CYCLES(STUP),
    .ACK_HOLD_CYCLES(AHOLD)) DUT (.clk(clk), .reset(reset), .mode_data_in(line), .mode_data_out(dout),
    .mode_data_oe(oe), .voltage_select_pin(vsel), .converter1_enable(en1), .converter2_enable(en2),
    .vout_update_ready(upd_ready), .forced_pwm(pwm), .conv1_voltage_code(c1), .conv2_voltage_code(c2),
    .interface_ready(ready));
  link_host host (.clk(clk), .mode_data_oe(oe), .line(line), .busy(busy));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (busy === 1'b1 && pwm !== 1'b1) pwm_drop <= pwm_drop + 1;
  end
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    test_done();
  end

  function automatic logic [31:0] next();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic check_regs();
    check(c1, vsel ? regs[1] : regs[0]);
    check(c2, regs[2]);
  endtask
  // A frame is accepted only when nothing is wrong with it and the buffer has room.
  task automatic send(input logic [1:0] sel, input logic [4:0] code, input logic req, input logic [7:0] addr,
                      input int bad, input logic ok);
    logic acked;
    logic acc;
    logic good;
    int dly;
    // Select 11 is still buffered and acknowledged, but it writes no register.
    acc = ok && addr == OWN_ADDR && bad < 0 && pend.size() < 16;
    good = acc && sel != 2'h3;
    host.frame(addr, {req, sel, code}, 4 + int'(next() % 7), bad, acked, dly);
    if (good && upd_ready) regs[sel] = code;
    else if (acc && !upd_ready) pend.push_back(code);
    check(acked, req & acc);
    if (req & acc) begin
      check(dly >= link_pkg::ACK_VALID_CYCLES && dly <= link_pkg::ACK_VALID_CYCLES + 8, 1);
      check(host.ack_len, AHOLD);
    end
    repeat (4) @(negedge clk);
    check_regs();
  endtask
  task automatic test_done();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    vsel = 1'b0;
    en1 = 1'b0;
    en2 = 1'b0;
    upd_ready = 1'b1;
    seed = 32'h0000_29e3;
    error_cnt = 0;
    num_checks = 0;
    pwm_drop = 0;
    for (int i = 0; i < 3; i++) regs[i] = 5'h00;
    repeat (16) @(negedge clk);
    check({pwm, c1, c2, oe, ready, dout}, {1'b1, 10'h000, 3'h0});
    reset = 1'b0;
    repeat (STUP + 20) @(negedge clk);
    check(ready, 0);
    en2 = 1'b1;
    repeat (STUP - 10) @(negedge clk);
    check(ready, 0);
    repeat (20) @(negedge clk);
    check(ready, 1);
    check(pwm, 1);
    host.hold(1'b1, TMO - 20);
    check(pwm, 1);
    host.hold(1'b1, 40);
    check(pwm, 0);
    host.hold(1'b0, 5);
    check(pwm, 1);
    for (int i = 0; i < 12; i++) begin
      vsel = next() % 2;
      send(next() % 3, next(), next() % 2, OWN_ADDR, -1, 1'b1);
    end
    send(2'h2, 5'h15, 1'b1, OWN_ADDR ^ 8'h01, -1, 1'b1);
    send(2'h3, 5'h0a, 1'b1, OWN_ADDR, -1, 1'b1);
    send(2'h1, 5'h1b, 1'b1, OWN_ADDR, 3, 1'b1);
    // A frame right after dropping the line is misaligned; the timeout realigns the receiver.
    host.hold(1'b1, 60);
    send(2'h0, 5'h1f, 1'b1, OWN_ADDR, -1, 1'b0);
    host.hold(1'b1, TMO + 20);
    en2 = 1'b0;
    repeat (20) @(negedge clk);
    check(ready, 0);
    vsel = ~vsel;
    send(2'h2, 5'h11, 1'b1, OWN_ADDR, -1, 1'b0);
    en1 = 1'b1;
    repeat (STUP + 10) @(negedge clk);
    check(ready, 1);
    upd_ready = 1'b0;
    for (int i = 0; i < 17; i++) send(2'h2, next(), i == 16 || next() % 2, OWN_ADDR, -1, 1'b1);
    for (int i = 0; i < 60; i++) begin
      @(negedge clk);
      upd_ready = next() % 2;
    end
    upd_ready = 1'b1;
    repeat (40) @(negedge clk);
    regs[2] = pend[$];
    check_regs();
    check(pwm_drop, 0);
    test_done();
  end
endmodule
